/* File: design/timer_irq_regs.svh */
// register map, field positions, reset values and timing counts of the timer interrupt block
`ifndef TIMER_IRQ_REGS_SVH
`define TIMER_IRQ_REGS_SVH

`define TIRQ_OFS_STATUS    12'h000
`define TIRQ_OFS_ENABLE    12'h004
`define TIRQ_OFS_ROUTE     12'h008
`define TIRQ_OFS_LIMIT     12'h00c
`define TIRQ_OFS_COUNT     12'h010
`define TIRQ_OFS_TOGGLE    12'h014
`define TIRQ_OFS_PINS      12'h018
`define TIRQ_OFS_CHAN0     12'h020

`define TIRQ_WRAP_BIT      8
`define TIRQ_ROUTE_RESET   8'h00
`define TIRQ_ENABLE_RESET  9'h000
`define TIRQ_LIMIT_RESET   16'hffff
`define TIRQ_PHASE_DIV     2

`endif

/* File: design/timer_irq_pkg.sv */
// types shared by the timer interrupt block
package timer_irq_pkg;
  typedef enum logic [1:0] {
    PH_A,
    PH_B
  } phase_t;
endpackage

/* File: design/flag_cell.sv */
// one event flag with read-then-write-zero clear and transfer-engine clear
`timescale 1ns/1ps
`default_nettype none
module flag_cell
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // flag events
  input  wire logic setEvent,
  input  wire logic armRead,
  input  wire logic writeZero,
  input  wire logic engineClear,
  input  wire logic engineMode,
  // state
  output logic      flag
);
  logic armed;

  // armed by a read seeing the flag at one
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      armed <= 1'b0;
    else if (setEvent)
      armed <= 1'b0;
    else if (armRead && flag)
      armed <= 1'b1;
    else if (writeZero)
      armed <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      flag <= 1'b0;
    else if (setEvent)
      flag <= 1'b1; // see RQ9
    else if (engineMode && engineClear)
      flag <= 1'b0; // see RQ19
    else if (!engineMode && writeZero && armed)
      flag <= 1'b0; // see RQ8
  end
endmodule
`default_nettype wire

/* File: design/timer_irq.sv */
// timer interrupt, flag and service-request routing block with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_regs.svh"
// How it works
// RQ1 - one wrap source and one source per channel, each masked by own enable
// RQ2 - route bit one sends channel event to transfer engine, zero to cpu
// RQ3 - reset clears all route bits, so channels go to cpu
// RQ4 - routed channel never raises a cpu request
// RQ5 - integrator serves channel 0 first, wrap last; not done here
// RQ6 - flags set and clear regardless of enable bits
// RQ7 - wrap sets wrap flag; capture, compare or pwm match sets channel flag
// RQ8 - cpu clears flag by reading it at one then writing zero
// RQ9 - new event between read and write keeps the flag set
// RQ10 - request line follows flag and enable while flag stays one
// RQ11 - counter steps on phase a strobe, at phase a rate when fastest
// RQ12 - wrap flag sets on the phase a strobe after reaching the limit
// RQ13 - setting the wrap flag returns the counter to zero
// RQ14 - on wrap, pins with toggle bit set toggle
// RQ15 - capture edge sets flag and request on next phase a strobe; the registered request here rises one clock after the flag
// RQ16 - capture latches counter into channel value on phase b strobe
// RQ17 - software keeps buffered compare channels off the transfer engine
// RQ18 - channel count is a parameter of two, four, six or eight
// RQ19 - on engine path, low byte access of channel value clears flag
// RQ20 - two phases modelled as strobes on one rising clock
module timer_irq
#(
  parameter int CHANNELS = 4 // see RQ18
)
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // datapath events
  input  wire logic [CHANNELS-1:0] captureEdge,
  input  wire logic [CHANNELS-1:0] compareMatch,
  input  wire logic [7:0]          prescaleSel,
  // transfer engine low byte access
  input  wire logic [CHANNELS-1:0] lowByteAccess,
  // requests and pins
  output logic [CHANNELS-1:0]      chanCpuRequest,
  output logic [CHANNELS-1:0]      chanTransferRequest,
  output logic                     wrapCpuRequest,
  output logic [CHANNELS-1:0]      channelPin
);
  localparam int NF = CHANNELS + 1;

  ////////////////////////////////////////////////////////////////
  // phase strobes
  timer_irq_pkg::phase_t phase_q;
  logic phaseA;
  logic phaseB;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      phase_q <= timer_irq_pkg::PH_A;
    else
      case (phase_q)
        timer_irq_pkg::PH_A: phase_q <= timer_irq_pkg::PH_B;
        timer_irq_pkg::PH_B: phase_q <= timer_irq_pkg::PH_A;
        default:             phase_q <= timer_irq_pkg::PH_A;
      endcase
  end

  assign phaseA = (phase_q == timer_irq_pkg::PH_A); // see RQ20
  assign phaseB = (phase_q == timer_irq_pkg::PH_B); // see RQ20

  ////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [CHANNELS-1:0] capS1_q;
  logic [CHANNELS-1:0] capS2_q;
  logic [CHANNELS-1:0] capS3_q;
  logic [CHANNELS-1:0] capSeen_q;
  logic [CHANNELS-1:0] cmpSeen_q;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      capS1_q <= '0;
      capS2_q <= '0;
      capS3_q <= '0;
    end
    else
    begin
      capS1_q <= captureEdge;
      capS2_q <= capS1_q;
      capS3_q <= capS2_q;
    end
  end

  // pending events held until the next phase a strobe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      capSeen_q <= '0;
      cmpSeen_q <= '0;
    end
    else if (phaseA)
    begin
      capSeen_q <= capS2_q & ~capS3_q;
      cmpSeen_q <= compareMatch;
    end
    else
    begin
      capSeen_q <= capSeen_q | (capS2_q & ~capS3_q);
      cmpSeen_q <= cmpSeen_q | compareMatch;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]          route_q;
  logic [NF-1:0]       enable_q;
  logic [15:0]         limit_q;
  logic [15:0]         count_q;
  logic [CHANNELS-1:0] toggleOnWrap_q;
  logic [15:0]         chanValue_q [CHANNELS];
  logic [7:0]          preCount_q;
  logic [NF-1:0]       flags;
  logic                wrapSet;
  logic                countTick;
  logic                wrAcc;
  logic                rdAcc;
  logic [CHANNELS-1:0] capNow_q;

  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      route_q        <= `TIRQ_ROUTE_RESET; // see RQ3
      enable_q       <= NF'(`TIRQ_ENABLE_RESET);
      limit_q        <= `TIRQ_LIMIT_RESET;
      toggleOnWrap_q <= '0;
    end
    else if (wrAcc)
    begin
      case (paddr)
        `TIRQ_OFS_ENABLE: enable_q <= pwdata[NF-1:0];
        `TIRQ_OFS_ROUTE:  route_q <= pwdata[7:0] & 8'((1 << CHANNELS) - 1);
        `TIRQ_OFS_LIMIT:  limit_q <= pwdata[15:0];
        `TIRQ_OFS_TOGGLE: toggleOnWrap_q <= pwdata[CHANNELS-1:0];
        default:          ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // counter
  assign countTick = phaseA && (preCount_q == prescaleSel);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      preCount_q <= '0;
    else if (phaseA)
      preCount_q <= (preCount_q == prescaleSel) ? 8'h00 : preCount_q + 8'h01;
  end

  // wrap flag sets on the phase a strobe once the limit is reached
  assign wrapSet = phaseA && (count_q == limit_q); // see RQ12

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      count_q <= '0;
    else if (wrapSet)
      count_q <= '0; // see RQ13
    else if (countTick)
      count_q <= count_q + 16'h0001; // see RQ11
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      channelPin <= '0;
    else if (wrapSet)
      channelPin <= channelPin ^ toggleOnWrap_q; // see RQ14
  end

  // capture latch on the phase b after the flag sets
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      capNow_q <= '0;
    else if (phaseA)
      capNow_q <= capSeen_q;
  end

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (wrAcc && paddr == 12'(`TIRQ_OFS_CHAN0 + 4 * i))
        chanValue_q[i] <= pwdata[15:0];
      else if (phaseB && capNow_q[i])
        chanValue_q[i] <= count_q; // see RQ16
    end
  end

  ////////////////////////////////////////////////////////////////
  // flags
  logic [NF-1:0] setEv;
  logic [NF-1:0] engMode;
  logic [NF-1:0] engClr;
  logic          stRead;
  logic          stWrite;

  assign stRead  = rdAcc && paddr == `TIRQ_OFS_STATUS;
  assign stWrite = wrAcc && paddr == `TIRQ_OFS_STATUS;

  // see RQ7, RQ15
  assign setEv   = {wrapSet, {CHANNELS{phaseA}} & (capSeen_q | cmpSeen_q)};
  assign engMode = {1'b0, route_q[CHANNELS-1:0]};
  assign engClr  = {1'b0, lowByteAccess};

  for (genvar g = 0; g < NF; g++)
  begin : g_flag
    flag_cell u_flag
    (
      .clk        (clk),
      .rst_b      (rst_b),
      .setEvent   (setEv[g]),
      .armRead    (stRead && prdata[g]), // see RQ8
      .writeZero  (stWrite && !pwdata[g]),
      .engineClear(engClr[g]),
      .engineMode (engMode[g]),
      .flag       (flags[g])
    );
  end

  ////////////////////////////////////////////////////////////////
  // request routing
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chanCpuRequest      <= '0;
      chanTransferRequest <= '0;
      wrapCpuRequest      <= 1'b0;
    end
    else
    begin
      // see RQ1, RQ6, RQ10
      chanCpuRequest      <= flags[CHANNELS-1:0] & enable_q[CHANNELS-1:0] & ~route_q[CHANNELS-1:0]; // see RQ2, RQ4
      chanTransferRequest <= flags[CHANNELS-1:0] & enable_q[CHANNELS-1:0] & route_q[CHANNELS-1:0]; // see RQ2
      wrapCpuRequest      <= flags[NF-1] & enable_q[NF-1];
    end
  end

  ////////////////////////////////////////////////////////////////
  // apb read side
  logic [31:0] rdMux;
  logic        known;

  always_comb
  begin
    rdMux = 32'h0000_0000;
    known = 1'b1;
    case (paddr)
      `TIRQ_OFS_STATUS: rdMux[NF-1:0] = flags;
      `TIRQ_OFS_ENABLE: rdMux[NF-1:0] = enable_q;
      `TIRQ_OFS_ROUTE:  rdMux[7:0] = route_q;
      `TIRQ_OFS_LIMIT:  rdMux[15:0] = limit_q;
      `TIRQ_OFS_COUNT:  rdMux[15:0] = count_q;
      `TIRQ_OFS_TOGGLE: rdMux[CHANNELS-1:0] = toggleOnWrap_q;
      `TIRQ_OFS_PINS:   rdMux[CHANNELS-1:0] = channelPin;
      default:
      begin
        known = 1'b0;
        for (int i = 0; i < CHANNELS; i++)
          if (paddr == 12'(`TIRQ_OFS_CHAN0 + 4 * i))
          begin
            rdMux[15:0] = chanValue_q[i];
            known = 1'b1;
          end
      end
    endcase
  end

  // no wait state: answer in the first access cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      prdata  <= rdMux;
      pslverr <= psel && !penable && !known;
    end
  end
endmodule
`default_nettype wire

/* File: verif/timer_irq_chk.sv */
// port assertions of the timer interrupt block
`timescale 1ns/1ps
`default_nettype none
module timer_irq_chk
#(
  parameter int CHANNELS = 4
)
(
  // clock, reset, apb
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pready,
  input wire logic [31:0]         prdata,
  input wire logic                pslverr,
  // requests
  input wire logic [CHANNELS-1:0] lowByteAccess,
  input wire logic [CHANNELS-1:0] chanCpuRequest,
  input wire logic [CHANNELS-1:0] chanTransferRequest,
  input wire logic                wrapCpuRequest
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [3:0] wrHist_q;
  logic [3:0] lbaHist_q;
  // recent clearing causes
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      wrHist_q  <= 4'h0;
      lbaHist_q <= 4'h0;
    end
    else
    begin
      wrHist_q  <= {wrHist_q[2:0], psel & penable & pwrite};
      lbaHist_q <= {lbaHist_q[2:0], |lowByteAccess};
    end
  AST_ROUTE_EXCL: assert property (~|(chanCpuRequest & chanTransferRequest))
    else $error("channel on both paths");
  AST_READY_NEXT: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_READY_ACC: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("error read not zero");
  AST_CPU_HOLD: assert property (|($past(chanCpuRequest) & ~chanCpuRequest) |-> |wrHist_q)
    else $error("cpu request fell alone");
  AST_XFER_HOLD: assert property (|($past(chanTransferRequest) & ~chanTransferRequest) |-> |(wrHist_q | lbaHist_q))
    else $error("transfer request fell alone");
  AST_WRAP_HOLD: assert property ($fell(wrapCpuRequest) |-> |wrHist_q)
    else $error("wrap request fell alone");
  cover property (pready && pslverr);
  cover property (|chanTransferRequest ##[1:50] |lowByteAccess);
  cover property ($rose(wrapCpuRequest));
endmodule
bind timer_irq timer_irq_chk #(.CHANNELS(CHANNELS)) chk (.clk(clk), .rst_b(rst_b), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .lowByteAccess(lowByteAccess), .chanCpuRequest(chanCpuRequest),
  .chanTransferRequest(chanTransferRequest), .wrapCpuRequest(wrapCpuRequest));
`default_nettype wire

/* File: verif/timer_far_side.sv */
// interrupt integrator and transfer engine model
`timescale 1ns/1ps
`default_nettype none
module timer_far_side
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // requests and answers
  input  wire logic       slow,
  input  wire logic [3:0] xferReq,
  input  wire logic [3:0] cpuReq,
  input  wire logic       wrapReq,
  output logic      [3:0] lowByteAccess,
  output logic      [2:0] cpuPick
);
  logic [5:0] cnt_q;
  // channel 0 first, wrap last
  always_comb
  begin
    cpuPick = wrapReq ? 3'h4 : 3'h7;
    for (int i = 3; i >= 0; i--)
      if (cpuReq[i])
        cpuPick = i[2:0];
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      cnt_q         <= 6'h0;
      lowByteAccess <= 4'h0;
    end
    else
    begin
      lowByteAccess <= 4'h0;
      cnt_q         <= (|xferReq) ? cnt_q + 6'h1 : 6'h0;
      if ((|xferReq) && cnt_q == (slow ? 6'h28 : 6'h3))
      begin
        lowByteAccess <= xferReq;
        cnt_q         <= 6'h0;
      end
    end
endmodule
`default_nettype wire

/* File: verif/timer_interrupt_routing_tb_top.sv */
// testbench of the timer interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "timer_irq_regs.svh"
module timer_interrupt_routing_tb_top;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, wrapReq, slow, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, c;
  logic [3:0]  capEdge, match, lba, cpuReq, xferReq, pins;
  logic [7:0]  preSel;
  int          n_mismatch, n_checks;
  timer_irq #(.CHANNELS(4)) uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .captureEdge(capEdge),
    .compareMatch(match), .prescaleSel(preSel), .lowByteAccess(lba), .chanCpuRequest(cpuReq),
    .chanTransferRequest(xferReq), .wrapCpuRequest(wrapReq), .channelPin(pins));
  timer_far_side far (.clk(clk), .rst_b(rst_b), .slow(slow), .xferReq(xferReq), .cpuReq(cpuReq),
    .wrapReq(wrapReq), .lowByteAccess(lba), .cpuPick());
  always #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, wr, a, d};
    @(posedge clk);
    penable <= 1'h1;
    do
      @(posedge clk);
    while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(r, exp);
  endtask
  task automatic pulse(input logic [3:0] m);
    match <= m;
    repeat (2) @(posedge clk);
    match <= 4'h0;
    repeat (8) @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    int n;
    clk = 1'h0;
    rst_b = 1'h0;
    {psel, penable, pwrite, paddr, pwdata, capEdge, match, preSel} = '0;
    slow = 1'h1;
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rdc(`TIRQ_OFS_ROUTE, 32'h0);
    apb(1'h0, 12'h0fc, 32'h0);
    chk({r[30:0], e}, 32'h1);
    // short wrap with pins 0 and 2 toggling
    apb(1'h1, `TIRQ_OFS_ENABLE, 32'h10);
    apb(1'h1, `TIRQ_OFS_TOGGLE, 32'h5);
    apb(1'h1, `TIRQ_OFS_LIMIT, 32'h10);
    n = 0;
    while (wrapReq !== 1'h1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk(pins, 32'h5);
    apb(1'h0, `TIRQ_OFS_COUNT, 32'h0);
    chk(r < 32'h4, 32'h1);
    apb(1'h1, `TIRQ_OFS_LIMIT, 32'hffff);
    rdc(`TIRQ_OFS_STATUS, 32'h10);
    apb(1'h1, `TIRQ_OFS_STATUS, 32'h0);
    pulse(4'h4);
    chk(cpuReq, 32'h0);
    rdc(`TIRQ_OFS_STATUS, 32'h4);
    apb(1'h1, `TIRQ_OFS_STATUS, 32'h0);
    apb(1'h1, `TIRQ_OFS_ENABLE, 32'h1f);
    pulse(4'hf);
    chk(cpuReq, 32'hf);
    apb(1'h1, `TIRQ_OFS_STATUS, 32'h0);
    rdc(`TIRQ_OFS_STATUS, 32'hf);
    pulse(4'h2);
    apb(1'h1, `TIRQ_OFS_STATUS, 32'h0);
    rdc(`TIRQ_OFS_STATUS, 32'h2);
    apb(1'h1, `TIRQ_OFS_STATUS, 32'h0);
    apb(1'h1, `TIRQ_OFS_ROUTE, 32'h5);
    pulse(4'hf);
    chk({xferReq, cpuReq}, 32'h5a);
    rdc(`TIRQ_OFS_STATUS, 32'hf);
    apb(1'h1, `TIRQ_OFS_STATUS, 32'h0);
    chk(xferReq, 32'h5);
    repeat (50) @(posedge clk);
    rdc(`TIRQ_OFS_STATUS, 32'h0);
    slow <= 1'h0;
    pulse(4'h1);
    rdc(`TIRQ_OFS_STATUS, 32'h0);
    apb(1'h1, `TIRQ_OFS_ROUTE, 32'h0);
    apb(1'h1, `TIRQ_OFS_CHAN0 + 12'h00c, 32'hbeef);
    capEdge <= 4'h8;
    repeat (10) @(posedge clk);
    chk(cpuReq, 32'h8);
    apb(1'h0, `TIRQ_OFS_COUNT, 32'h0);
    c = r;
    apb(1'h0, `TIRQ_OFS_CHAN0 + 12'h00c, 32'h0);
    chk(c - r < 32'h10, 32'h1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
